// ---- logic/pci_target_ready_and_irq.sv ----
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Phase completes when both ready signals asserted
// - Assert target ready only with data/space
// - Target ready undriven during address phase
// - Target ready deasserted in first data clock
// - Wait until internal memory data valid
// - Wait on halt, control-block select, ROM grant
// - Disconnect with data after eight wait clocks
// - Retry if first transfer exceeds sixteen clocks
// - Prefer disconnect over long waits; master retries
// - Error interrupt changes synchronised to bus clock
// - No interrupt unless enabled and powered up
// - Interrupt line floats during bus reset
module pci_target_ready_and_irq (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM register slave
  input wire pci_trdy_pkg::avs_req_s avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // PCI target side
  input wire pci_trdy_pkg::pci_in_s pci_in,
  input wire pci_trdy_pkg::access_s access,
  input wire logic sequencer_halt_acknowledge,
  input wire logic internal_control_block_mem_select,
  input wire logic external_rom_arbitration_grant_n,
  output logic external_rom_arbitration_request_n,
  output logic trdy_n_out,
  output logic trdy_oe_n,
  output logic stop_n_out,
  output logic stop_oe_n,
  output logic phase_done,
  // Interrupt
  input wire logic host_bus_reset_in_n,
  input wire logic bus_error_evt,
  input wire logic parity_error_evt,
  output logic interrupt_request_out,
  output logic interrupt_request_oe_n
);
  import pci_trdy_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  pace_state_e st_r;
  logic [4:0] wait_cnt_r;
  logic first_r;
  logic disc_pend_r;
  logic is_read_r;
  logic [3:0] be_r;
  logic retry_evt_r;
  logic disc_evt_r;
  logic grant_meta_r;
  logic grant_sync_n_r;
  logic hbr_meta_r;
  logic hbr_sync_n_r;
  logic [1:0] host_ctrl_r;
  logic [3:0] int_mask_r;
  logic [3:0] int_status_r;
  logic [3:0] int_status_nxt;
  logic [31:0] rd_mux;
  logic data_ok;
  logic ready_ok;
  logic in_data;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic irq_pending;

  // ----------------------------------------
  // Synchronisers for off-chip levels
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      grant_meta_r <= 1'b1;
      grant_sync_n_r <= 1'b1;
      hbr_meta_r <= 1'b0;
      hbr_sync_n_r <= 1'b0;
    end else begin
      grant_meta_r <= external_rom_arbitration_grant_n;
      grant_sync_n_r <= grant_meta_r;
      hbr_meta_r <= host_bus_reset_in_n;
      hbr_sync_n_r <= hbr_meta_r;
    end
  end

  // Readiness of the current data phase
  assign data_ok = is_read_r ? access.mem_data_valid : access.write_can_accept;
  assign ready_ok = data_ok
                    & ~(access.reg_needs_halt & ~sequencer_halt_acknowledge)
                    & ~(access.cb_access & internal_control_block_mem_select)
                    & ~(access.rom_access & grant_sync_n_r);
  assign in_data = (st_r == ST_FIRST) || (st_r == ST_WAIT) || (st_r == ST_READY);

  // ----------------------------------------
  // Data-phase pacing state machine
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ST_IDLE;
      trdy_n_out <= 1'b1;
      trdy_oe_n <= 1'b1;
      stop_n_out <= 1'b1;
      stop_oe_n <= 1'b1;
      wait_cnt_r <= WAIT_CNT_START;
      first_r <= 1'b0;
      disc_pend_r <= 1'b0;
      is_read_r <= 1'b0;
      be_r <= 4'h0;
      phase_done <= 1'b0;
      retry_evt_r <= 1'b0;
      disc_evt_r <= 1'b0;
    end else begin
      phase_done <= 1'b0;
      retry_evt_r <= 1'b0;
      disc_evt_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          // Drive only after the address phase
          if (pci_in.addr_phase) begin
            st_r <= ST_FIRST;
            trdy_oe_n <= 1'b0;
            stop_oe_n <= 1'b0;
            trdy_n_out <= 1'b1;
            stop_n_out <= 1'b1;
            first_r <= 1'b1;
            disc_pend_r <= 1'b0;
            wait_cnt_r <= WAIT_CNT_START;
            is_read_r <= pci_in.is_read;
          end
        end
        ST_FIRST, ST_WAIT: begin
          if (st_r == ST_FIRST) begin
            be_r <= pci_in.byte_enable_n;
          end
          if (ready_ok) begin
            st_r <= ST_READY;
            trdy_n_out <= 1'b0;
            stop_n_out <= ~disc_pend_r;
          end else if (first_r && wait_cnt_r == RETRY_LIMIT) begin
            st_r <= ST_STOP;
            stop_n_out <= 1'b0;
            retry_evt_r <= 1'b1;
          end else begin
            st_r <= ST_WAIT;
            if (wait_cnt_r < RETRY_LIMIT) begin
              wait_cnt_r <= wait_cnt_r + 5'h01;
            end
            if (wait_cnt_r == DISC_LIMIT) begin
              disc_pend_r <= 1'b1;
            end
          end
        end
        ST_READY: begin
          // Complete only when initiator ready too
          if (!pci_in.irdy_n) begin
            phase_done <= 1'b1;
            first_r <= 1'b0;
            wait_cnt_r <= WAIT_CNT_START;
            trdy_n_out <= 1'b1;
            if (!stop_n_out) begin
              disc_evt_r <= 1'b1;
              st_r <= pci_in.frame_n ? ST_TAR : ST_STOP;
              stop_n_out <= pci_in.frame_n;
            end else begin
              st_r <= pci_in.frame_n ? ST_TAR : ST_WAIT;
            end
          end
        end
        ST_STOP: begin
          // Hold stop until the last phase ends
          if (pci_in.frame_n && !pci_in.irdy_n) begin
            st_r <= ST_TAR;
            stop_n_out <= 1'b1;
          end
        end
        ST_TAR: begin
          trdy_oe_n <= 1'b1;
          stop_oe_n <= 1'b1;
          st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ROM arbitration request throughout a ROM data phase, registered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      external_rom_arbitration_request_n <= 1'b1;
    end else begin
      external_rom_arbitration_request_n <= ~(access.rom_access && in_data);
    end
  end

  a_addr_no_drive: assert property ((st_r == ST_IDLE) |-> trdy_oe_n)
    else $error("target ready driven outside data phases");
  a_first_clock_wait: assert property ((st_r == ST_IDLE && pci_in.addr_phase) |=> (!trdy_oe_n && trdy_n_out))
    else $error("target ready asserted in first data clock");
  a_ready_follows: assert property ((in_data && st_r != ST_READY && ready_ok) |=> !trdy_n_out)
    else $error("target ready late after data ready");
  a_wait_holds: assert property ((in_data && st_r != ST_READY && !ready_ok) |=> trdy_n_out)
    else $error("target ready asserted without data ready");
  a_blocked_wait: assert property ((in_data && st_r != ST_READY && access.cb_access
                                   && internal_control_block_mem_select) |=> trdy_n_out)
    else $error("target ready during control block select");
  a_hold_till_irdy: assert property ((st_r == ST_READY && pci_in.irdy_n) |=> (st_r == ST_READY && !trdy_n_out))
    else $error("phase ended without initiator ready");

  sequence s_wait_first_limit;
    (st_r == ST_WAIT) && first_r && (wait_cnt_r == RETRY_LIMIT) && !ready_ok;
  endsequence
  sequence s_retry_hold;
    !stop_n_out && trdy_n_out && (st_r == ST_STOP);
  endsequence
  a_retry_at_limit: assert property (s_wait_first_limit |=> s_retry_hold)
    else $error("no retry after sixteen wait clocks");
  a_disc_pending: assert property (((st_r == ST_WAIT) && !ready_ok && (wait_cnt_r == DISC_LIMIT))
                                   |=> disc_pend_r)
    else $error("disconnect not armed after eight wait clocks");
  a_disc_with_data: assert property ((in_data && st_r != ST_READY && ready_ok && disc_pend_r)
                                     |=> (!trdy_n_out && !stop_n_out))
    else $error("disconnect not signalled with data");

  // ----------------------------------------
  // Avalon-MM slave, one wait state per access
  // ----------------------------------------
  assign acc = (avs_req.read | avs_req.write) & ~avs_waitrequest;
  assign wr_acc = acc & avs_req.write;
  assign rd_acc = acc & avs_req.read;

  // Read data selection, unmapped reads as zero
  always_comb begin
    rd_mux = 32'h0;
    case (avs_req.address)
      OFS_HOST_CTRL: rd_mux[1:0] = host_ctrl_r;
      OFS_INT_STATUS: rd_mux[3:0] = int_status_r;
      OFS_INT_MASK: rd_mux[3:0] = int_mask_r;
      OFS_PACE_STATUS: rd_mux[15:0] = {be_r, first_r, wait_cnt_r, st_r};
      default: rd_mux = 32'h0;
    endcase
  end

  // Handshake and read data capture
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else if ((avs_req.read | avs_req.write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= rd_mux;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Control and mask registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      host_ctrl_r <= HOST_CTRL_RESET;
      int_mask_r <= INT_MASK_RESET;
    end else begin
      if (wr_acc && avs_req.address == OFS_HOST_CTRL) begin
        host_ctrl_r <= avs_req.writedata[1:0];
      end
      if (wr_acc && avs_req.address == OFS_INT_MASK) begin
        int_mask_r <= avs_req.writedata[3:0];
      end
    end
  end

  // ----------------------------------------
  // Interrupt status and open-drain request
  // ----------------------------------------
  always_comb begin
    // Clear only the bits handed out, later events survive the read
    int_status_nxt = (rd_acc && avs_req.address == OFS_INT_STATUS) ? (int_status_r & ~avs_readdata[3:0])
                     : int_status_r;
    int_status_nxt[EV_BUS_ERR_POS] = int_status_nxt[EV_BUS_ERR_POS] | bus_error_evt;
    int_status_nxt[EV_PAR_ERR_POS] = int_status_nxt[EV_PAR_ERR_POS] | parity_error_evt;
    int_status_nxt[EV_RETRY_POS] = int_status_nxt[EV_RETRY_POS] | retry_evt_r;
    int_status_nxt[EV_DISC_POS] = int_status_nxt[EV_DISC_POS] | disc_evt_r;
  end

  // Sticky events, set wins over read clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_status_r <= INT_STATUS_RESET;
    end else begin
      int_status_r <= int_status_nxt;
    end
  end

  assign irq_pending = |(int_status_r & int_mask_r);

  // Line pulled low only when enabled, powered and out of bus reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      interrupt_request_oe_n <= 1'b1;
      interrupt_request_out <= 1'b0;
    end else begin
      interrupt_request_out <= 1'b0;
      interrupt_request_oe_n <= ~(irq_pending && host_ctrl_r[INT_EN_POS]
                                  && !host_ctrl_r[PWR_DN_POS] && hbr_sync_n_r);
    end
  end

  a_err_sticky: assert property (bus_error_evt |=> int_status_r[EV_BUS_ERR_POS] and
                                 ((int_mask_r[EV_BUS_ERR_POS] && host_ctrl_r[INT_EN_POS] && !host_ctrl_r[PWR_DN_POS]
                                 && hbr_sync_n_r) |=> !interrupt_request_oe_n))
    else $error("bus error not latched on next clock");
  a_irq_gated: assert property ((!host_ctrl_r[INT_EN_POS] || host_ctrl_r[PWR_DN_POS]) |=> interrupt_request_oe_n)
    else $error("interrupt driven while disabled");
  a_irq_float_rst: assert property (!hbr_sync_n_r |=> interrupt_request_oe_n)
    else $error("interrupt driven during bus reset");
  a_irq_drives: assert property ((irq_pending && host_ctrl_r[INT_EN_POS] && !host_ctrl_r[PWR_DN_POS]
                                 && hbr_sync_n_r) |=> (!interrupt_request_oe_n && !interrupt_request_out))
    else $error("pending interrupt not driven low");
endmodule
`default_nettype wire

// ---- logic/pci_trdy_pkg.sv ----
`default_nettype none
package pci_trdy_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] OFS_HOST_CTRL = 4'h0;
  localparam logic [3:0] OFS_INT_STATUS = 4'h4;
  localparam logic [3:0] OFS_INT_MASK = 4'h8;
  localparam logic [3:0] OFS_PACE_STATUS = 4'hc;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int INT_EN_POS = 0;
  localparam int PWR_DN_POS = 1;
  localparam int EV_BUS_ERR_POS = 0;
  localparam int EV_PAR_ERR_POS = 1;
  localparam int EV_RETRY_POS = 2;
  localparam int EV_DISC_POS = 3;
  localparam logic [1:0] HOST_CTRL_RESET = 2'h0;
  localparam logic [3:0] INT_MASK_RESET = 4'h0;
  localparam logic [3:0] INT_STATUS_RESET = 4'h0;

  // ----------------------------------------
  // Wait-state limits in bus clocks
  // ----------------------------------------
  localparam logic [4:0] DISC_LIMIT = 5'h08;
  localparam logic [4:0] RETRY_LIMIT = 5'h10;
  localparam logic [4:0] WAIT_CNT_START = 5'h01;

  // ----------------------------------------
  // Carriers and states
  // ----------------------------------------
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } avs_req_s;

  typedef struct packed {
    logic frame_n;
    logic irdy_n;
    logic addr_phase;
    logic is_read;
    logic [3:0] byte_enable_n;
  } pci_in_s;

  typedef struct packed {
    logic mem_data_valid;
    logic write_can_accept;
    logic reg_needs_halt;
    logic cb_access;
    logic rom_access;
  } access_s;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_FIRST = 6'h02,
    ST_WAIT = 6'h04,
    ST_READY = 6'h08,
    ST_STOP = 6'h10,
    ST_TAR = 6'h20
  } pace_state_e;
endpackage
`default_nettype wire

// ---- test/pci_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// PCI master on the far side of the target
module pci_master_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Test control
  input wire logic start,
  input wire logic rd,
  input wire logic [3:0] nph,
  input wire logic slow,
  output logic busy,
  // Bus lines, pulled up when released
  input wire logic trdy_n,
  input wire logic stop_n,
  output var pci_trdy_pkg::pci_in_s pin
);
  import pci_trdy_pkg::*;
  logic [3:0] left;
  logic hit;
  // Phase done when both ready lines are low
  assign hit = !pin.irdy_n && !trdy_n;
  // Address phase, data phases, stop handling
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin <= '{1'b1, 1'b1, 1'b0, 1'b0, 4'h5};
      busy <= 1'b0;
      left <= 4'h0;
    end else if (start && !busy) begin
      pin <= '{1'b0, 1'b1, 1'b1, rd, 4'h0};
      busy <= 1'b1;
      left <= nph;
    end else if (pin.addr_phase) begin
      pin.addr_phase <= 1'b0;
      pin.irdy_n <= 1'b0;
      pin.frame_n <= left == 4'h1;
    end else if (busy && pin.irdy_n) begin
      pin.irdy_n <= 1'b0;
    end else if (busy && (hit || !stop_n)) begin
      left <= left - 4'(hit);
      if (pin.frame_n) begin
        // Last phase or stopped: the master releases irdy and goes idle
        pin.irdy_n <= 1'b1;
        busy <= 1'b0;
      end else begin
        pin.frame_n <= !stop_n || left == 4'h2;
        pin.irdy_n <= slow && stop_n && left != 4'h2;
      end
    end else if (!busy) begin
      // Released byte enables do not keep their last value
      pin.byte_enable_n <= ~pin.byte_enable_n;
    end
  end
endmodule
`default_nettype wire

// ---- test/pci_target_ready_and_irq_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module pci_target_ready_and_irq_tb;
  import pci_trdy_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  avs_req_s avs_req = '0;
  pci_in_s pin;
  access_s access = 5'h18;
  logic halt_ack = 1'b1, cb_sel = 1'b0, gnt_n = 1'b0, bus_rst_n = 1'b1, bus_err = 1'b0, par_err = 1'b0;
  logic start = 1'b0, rd = 1'b0, slow = 1'b0, rom_seen = 1'b0, ap_d = 1'b0, blk_d = 1'b0, trdy_d = 1'b1;
  logic stop_d = 1'b1, sw_trdy = 1'b0, busy, rom_req_n, trdy_n, trdy_oe_n, stop_n, stop_oe_n;
  logic phase_done, irq_out, irq_oe_n, avs_waitrequest;
  logic [31:0] avs_readdata, rdq;
  logic [3:0] nph = 4'h1;
  logic [1:0] gnt_h = 2'h0;
  logic [3:0] ofs [4] = '{OFS_HOST_CTRL, OFS_INT_STATUS, OFS_INT_MASK, 4'h2};
  access_s cause [4] = '{5'h08, 5'h1c, 5'h1a, 5'h19};
  int compares = 0, miscompares = 0, pd = 0, cyc = 0, stop_at = 0;
  // Wire levels with the bus pull-ups
  wire trdy_w = trdy_oe_n ? 1'b1 : trdy_n;
  wire stop_w = stop_oe_n ? 1'b1 : stop_n;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  pci_target_ready_and_irq pci_target_ready_and_irq_i (.clk(clk), .reset_n(reset_n), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pci_in(pin), .access(access),
    .sequencer_halt_acknowledge(halt_ack), .internal_control_block_mem_select(cb_sel),
    .external_rom_arbitration_grant_n(gnt_n), .external_rom_arbitration_request_n(rom_req_n),
    .trdy_n_out(trdy_n), .trdy_oe_n(trdy_oe_n), .stop_n_out(stop_n), .stop_oe_n(stop_oe_n),
    .phase_done(phase_done), .host_bus_reset_in_n(bus_rst_n), .bus_error_evt(bus_err),
    .parity_error_evt(par_err), .interrupt_request_out(irq_out), .interrupt_request_oe_n(irq_oe_n));
  pci_master_model pci_master_model_i (.clk(clk), .reset_n(reset_n), .start(start), .rd(rd), .nph(nph),
    .slow(slow), .busy(busy), .trdy_n(trdy_w), .stop_n(stop_w), .pin(pin));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic rg(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_req <= '{!w, w, a, d};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rdq = avs_readdata;
    avs_req <= '0;
  endtask
  // One transaction of the master model, waited out to idle
  task automatic txn(input logic r, input logic [3:0] n, input logic s);
    @(posedge clk);
    rd <= r;
    nph <= n;
    slow <= s;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do begin
      @(posedge clk);
    end while (busy !== 1'b0);
    repeat (3) @(posedge clk);
  endtask
  // One-clock error event
  task automatic ev(input logic p);
    @(posedge clk);
    bus_err <= !p;
    par_err <= p;
    @(posedge clk);
    bus_err <= 1'b0;
    par_err <= 1'b0;
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Pin watcher: pacing, stop timing, interrupt pin value
  always @(posedge clk) begin
    if (pin.addr_phase === 1'b1) chk(32'(trdy_oe_n), 32'h1);
    if (ap_d === 1'b1) chk(32'(trdy_w), 32'h1);
    if (trdy_w === 1'b0 && trdy_d === 1'b1) chk(32'(blk_d), 32'h0);
    if (reset_n) chk(32'(irq_out), 32'h0);
    if (phase_done === 1'b1) pd++;
    if (rom_req_n === 1'b0) rom_seen = 1'b1;
    cyc = trdy_oe_n === 1'b0 ? cyc + 1 : 0;
    if (stop_w === 1'b0 && stop_d === 1'b1) begin
      stop_at = cyc;
      sw_trdy = trdy_w === 1'b0;
    end
    ap_d <= pin.addr_phase;
    trdy_d <= trdy_w;
    stop_d <= stop_w;
    gnt_h <= {gnt_h[0], gnt_n};
    blk_d <= (pin.is_read ? !access.mem_data_valid : !access.write_can_accept) || (access.reg_needs_halt && !halt_ack)
      || (access.cb_access && cb_sel) || (access.rom_access && |{gnt_h, gnt_n});
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    foreach (ofs[i]) begin
      rg(1'b0, ofs[i], 32'h0);
      chk(rdq, 32'h0);
    end
    rg(1'b1, OFS_PACE_STATUS, 32'hffff_ffff);
    rg(1'b0, OFS_PACE_STATUS, 32'h0);
    chk(32'(rdq[5:0]), 32'(ST_IDLE));
    // Prompt single read, then burst with a slow master
    txn(1'b1, 4'h1, 1'b0);
    chk(32'(pd), 32'h1);
    txn(1'b1, 4'h3, 1'b1);
    chk(32'(pd), 32'h4);
    // Each wait cause held a few clocks
    for (int i = 0; i < 4; i++) begin
      access <= cause[i];
      halt_ack <= i != 1;
      cb_sel <= i == 2;
      gnt_n <= i == 3;
      fork
        txn(1'b1, 4'h1, 1'b0);
        begin
          repeat (6) @(posedge clk);
          access <= cause[i] | 5'h10;
          halt_ack <= 1'b1;
          cb_sel <= 1'b0;
          gnt_n <= 1'b0;
        end
      join
      chk(32'(pd), 32'(5 + i));
    end
    chk(32'(rom_seen), 32'h1);
    // Long burst write wait ends in disconnect with data
    access <= 5'h10;
    fork
      txn(1'b0, 4'h2, 1'b0);
      begin
        repeat (14) @(posedge clk);
        access <= 5'h18;
      end
    join
    chk(32'(pd), 32'h9);
    chk(32'(sw_trdy && stop_at >= 9), 32'h1);
    rg(1'b0, OFS_INT_STATUS, 32'h0);
    chk(rdq, 32'h8);
    // Write never accepted ends in retry
    access <= 5'h10;
    txn(1'b0, 4'h1, 1'b0);
    access <= 5'h18;
    chk(32'(pd), 32'h9);
    chk(32'(!sw_trdy && stop_at >= 17 && stop_at <= 18), 32'h1);
    rg(1'b0, OFS_INT_STATUS, 32'h0);
    chk(rdq, 32'h4);
    // Interrupt raised, floated by bus reset, cleared
    rg(1'b1, OFS_INT_MASK, 32'hf);
    rg(1'b1, OFS_HOST_CTRL, 32'h1);
    ev(1'b0);
    @(posedge clk);
    chk(32'(irq_oe_n), 32'h1);
    @(posedge clk);
    chk(32'(irq_oe_n), 32'h0);
    bus_rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(irq_oe_n), 32'h1);
    bus_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'(irq_oe_n), 32'h0);
    rg(1'b0, OFS_INT_STATUS, 32'h0);
    chk(rdq, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq_oe_n), 32'h1);
    // Disabled, powered down, masked: line stays released
    for (int i = 0; i < 3; i++) begin
      rg(1'b1, OFS_HOST_CTRL, i == 1 ? 32'h3 : 32'(i >> 1));
      rg(1'b1, OFS_INT_MASK, i == 2 ? 32'h0 : 32'hf);
      ev(1'b1);
      repeat (4) @(posedge clk);
      chk(32'(irq_oe_n), 32'h1);
      rg(1'b0, OFS_INT_STATUS, 32'h0);
      chk(rdq, 32'h2);
    end
    wrap_up();
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
